// File: shared/hpp_defs.svh
/*
 constants for the host processor bus port: transfer sizes, widths, modes.
 assumes inclusion by bare name from the package and design files.
*/
`ifndef HPP_DEFS_SVH
`define HPP_DEFS_SVH
// Summary of operation
// R1: master drives transfer size: 01 byte, 10 half-word, 00 word.
// R2: burst in progress asks beat two ahead; drop it to abort burst.
// R3: acknowledge low when write data taken or read data driven.
// R4: error acknowledge low when internal bus reports an error.
// R5: port can ask the master to release the bus and retry.
// R6: data bus 8, 16 or 32 bits; master writes, port reads.
// R7: one parity bit per byte lane, width 1, 2 or 4 bits.
// R8: everything sampled and driven on rising edge of bus clock.
// R9: unused port turns its pins into general user pins; code hands over only data and control pins, parity pins stay undriven.
// R10: exactly one termination per transaction, never two at once.
`define HPP_TSZ_WORD   2'h0
`define HPP_TSZ_BYTE   2'h1
`define HPP_TSZ_HALF   2'h2
`define HPP_DW_8       2'h0
`define HPP_DW_16      2'h1
`define HPP_DW_32      2'h2
`define HPP_DATA_W     32
`define HPP_PAR_W      4
`define HPP_ADDR_W     22
`endif

// File: shared/hpp_pkg.sv
/*
 types for the host processor bus port.
 assumes hpp_defs.svh on the include path.
*/
`include "hpp_defs.svh"
package hpp_pkg;
   typedef enum logic [3:0] {
      HPP_IDLE = 4'h1,
      HPP_WAIT = 4'h2,
      HPP_RESP = 4'h4,
      HPP_BEAT = 4'h8
   } hpp_state_e;
   typedef struct packed {
      logic                       req;
      logic                       wr;
      logic [`HPP_ADDR_W-1:0]     addr;
      logic [1:0]                 size;
      logic [`HPP_DATA_W-1:0]     wdata;
      logic [`HPP_PAR_W-1:0]      be;
   } hpp_sreq_s;
   typedef struct packed {
      logic                       done;
      logic                       err;
      logic                       retry;
      logic [`HPP_DATA_W-1:0]     rdata;
   } hpp_srsp_s;
endpackage

// File: hdl/hpp_port.sv
/*
 device-side slave of the host processor bus: takes master cycles,
 forwards them to the internal system bus, terminates each cycle with
 acknowledge, error or retry, and hands the data and control pins to user logic when the
 port is not enabled.
 assumes one bus clock shared with the internal bus and a master that
 keeps its own signalling rules; pins are given as in, out and enable.
*/
`timescale 1ns/1ns
`include "hpp_defs.svh"
module hpp_port
   import hpp_pkg::*;
(
   input  wire logic                   ref_clk_i,
   input  wire logic                   rstn_i,
   input  wire logic                   port_en_i,
   input  wire logic                   cfg_done_i,
   input  wire logic [1:0]             bus_width_i,
   input  wire logic                   ts_n_i,
   input  wire logic                   rd_wr_i,
   input  wire logic [`HPP_ADDR_W-1:0] addr_i,
   input  wire logic [1:0]             transfer_size_i,
   input  wire logic                   burst_i,
   input  wire logic                   burst_data_in_progress_i,
   input  wire logic [`HPP_DATA_W-1:0] data_i,
   input  wire logic [`HPP_PAR_W-1:0]  byte_lane_parity_i,
   output logic [`HPP_DATA_W-1:0]      data_o,
   output logic [`HPP_DATA_W-1:0]      data_oe_n_o,
   output logic [`HPP_PAR_W-1:0]       byte_lane_parity_o,
   output logic [`HPP_PAR_W-1:0]       byte_lane_parity_oe_n_o,
   output logic                        transfer_acknowledge_n_o,
   output logic                        transfer_error_ack_n_o,
   output logic                        retry_request_o,
   output logic                        ctl_oe_n_o,
   output logic                        parity_err_o,
   output hpp_sreq_s                   sreq_o,
   input  wire hpp_srsp_s              srsp_i,
   input  wire logic [`HPP_DATA_W-1:0] user_data_i,
   input  wire logic [`HPP_DATA_W-1:0] user_data_oe_n_i,
   input  wire logic [2:0]             user_ctl_i,
   input  wire logic                   user_ctl_oe_n_i,
   output logic [`HPP_DATA_W-1:0]      user_data_o,
   output logic [2:0]                  user_ctl_o
);

   ////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [`HPP_PAR_W-1:0] lane_mask(
      input logic [1:0] w);
      case (w)
         `HPP_DW_8:  lane_mask = 4'h1;
         `HPP_DW_16: lane_mask = 4'h3;
         default:    lane_mask = 4'hF;
      endcase
   endfunction

   function automatic logic [`HPP_PAR_W-1:0] size_mask(
      input logic [1:0] s, input logic [1:0] w);
      logic [`HPP_PAR_W-1:0] m;
      m = lane_mask(w);
      case (s)
         `HPP_TSZ_BYTE: size_mask = 4'h1 & m;
         `HPP_TSZ_HALF: size_mask = 4'h3 & m;
         default:       size_mask = m;
      endcase
   endfunction

   function automatic logic [`HPP_PAR_W-1:0] lane_par(
      input logic [`HPP_DATA_W-1:0] d);
      logic [`HPP_PAR_W-1:0] p;
      p = 4'h0;
      for (int i = 0; i < `HPP_PAR_W; i++) begin
         p[i] = ^d[8*i +: 8]; // R7
      end
      lane_par = p;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // transaction state

   hpp_state_e                 st_q, st_d;
   hpp_sreq_s                  req_q, req_d;
   logic                       ack_q, ack_d;
   logic                       tea_q, tea_d;
   logic                       rty_q, rty_d;
   logic                       rd_q, rd_d;
   logic                       brst_q, brst_d;
   logic [`HPP_DATA_W-1:0]     rdat_q, rdat_d;
   logic                       perr_q, perr_d;
   logic                       active;

   // pins belong to the port only after configuration
   assign active = port_en_i & cfg_done_i; // R9

   always_comb begin
      st_d   = st_q;
      req_d  = req_q;
      ack_d  = 1'b0;
      tea_d  = 1'b0;
      rty_d  = 1'b0;
      rd_d   = 1'b0;
      brst_d = brst_q;
      rdat_d = rdat_q;
      perr_d = 1'b0;
      req_d.req = 1'b0;
      case (st_q)
         HPP_IDLE: begin
            if (active && !ts_n_i) begin // R8
               req_d.req   = 1'b1;
               req_d.wr    = ~rd_wr_i;
               req_d.addr  = addr_i;
               req_d.size  = transfer_size_i; // R1
               req_d.be    = size_mask(transfer_size_i, bus_width_i);
               req_d.wdata = data_i; // R6
               brst_d      = burst_i;
               if (!rd_wr_i) begin
                  perr_d = |((lane_par(data_i) ^ byte_lane_parity_i)
                            & size_mask(transfer_size_i, bus_width_i));
               end
               st_d = HPP_WAIT;
            end
         end
         HPP_WAIT: begin
            if (!active) begin
               st_d = HPP_IDLE;
            end else if (srsp_i.retry) begin
               rty_d = 1'b1; // R5
               st_d  = HPP_RESP;
            end else if (srsp_i.err) begin
               tea_d = 1'b1; // R4
               st_d  = HPP_RESP;
            end else if (srsp_i.done) begin
               ack_d  = 1'b1; // R3
               rd_d   = ~req_q.wr;
               rdat_d = srsp_i.rdata;
               st_d   = HPP_RESP;
            end
         end
         HPP_RESP: begin
            // burst continues only while the master still asks for beats
            if (brst_q && burst_data_in_progress_i && active) begin // R2
               req_d.req  = 1'b1;
               req_d.addr = req_q.addr + `HPP_ADDR_W'(4);
               req_d.wdata = data_i;
               st_d = HPP_BEAT;
            end else begin
               brst_d = 1'b0;
               st_d   = HPP_IDLE;
            end
         end
         HPP_BEAT: begin
            st_d = HPP_WAIT;
         end
         default: begin
            st_d = HPP_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_q   <= HPP_IDLE;
         req_q  <= '0;
         ack_q  <= 1'b0;
         tea_q  <= 1'b0;
         rty_q  <= 1'b0;
         rd_q   <= 1'b0;
         brst_q <= 1'b0;
         rdat_q <= '0;
         perr_q <= 1'b0;
      end else begin
         st_q   <= st_d;
         req_q  <= req_d;
         ack_q  <= ack_d;
         tea_q  <= tea_d;
         rty_q  <= rty_d;
         rd_q   <= rd_d;
         brst_q <= brst_d;
         rdat_q <= rdat_d;
         perr_q <= perr_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin registers

   logic [`HPP_DATA_W-1:0]     dout_q, dout_d;
   logic [`HPP_DATA_W-1:0]     doe_q, doe_d;
   logic [`HPP_PAR_W-1:0]      pout_q, pout_d;
   logic [`HPP_PAR_W-1:0]      poe_q, poe_d;
   logic                       ackn_q, ackn_d;
   logic                       tean_q, tean_d;
   logic                       rtyo_q, rtyo_d;
   logic                       coe_q, coe_d;
   logic [`HPP_DATA_W-1:0]     udat_q, udat_d;
   logic [2:0]                 uctl_q, uctl_d;
   logic [`HPP_PAR_W-1:0]      lanes;

   assign lanes = lane_mask(bus_width_i);

   always_comb begin
      // priority retry over error over ack keeps one response
      ackn_d = ~(ack_q & ~tea_q & ~rty_q); // R10
      tean_d = ~(tea_q & ~rty_q); // R10
      rtyo_d = rty_q;
      udat_d = data_i;
      uctl_d = {~transfer_acknowledge_n_o, ~transfer_error_ack_n_o,
                retry_request_o};
      if (active) begin
         dout_d = rdat_q;
         pout_d = lane_par(rdat_q);
         coe_d  = 1'b0;
         for (int i = 0; i < `HPP_PAR_W; i++) begin
            doe_d[8*i +: 8] = {8{~(rd_q & lanes[i])}}; // R6
            poe_d[i]        = ~(rd_q & lanes[i]);
         end
      end else begin
         dout_d = user_data_i; // R9
         doe_d  = user_data_oe_n_i;
         pout_d = 4'h0;
         poe_d  = 4'hF;
         coe_d  = user_ctl_oe_n_i;
         ackn_d = ~user_ctl_i[2];
         tean_d = ~user_ctl_i[1];
         rtyo_d = user_ctl_i[0];
      end
   end

   // one always_ff: pins change only on the bus clock edge or at asynchronous reset
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         dout_q <= '0;
         doe_q  <= '1;
         pout_q <= '0;
         poe_q  <= '1;
         ackn_q <= 1'b1;
         tean_q <= 1'b1;
         rtyo_q <= 1'b0;
         coe_q  <= 1'b1;
         udat_q <= '0;
         uctl_q <= '0;
      end else begin // R8
         dout_q <= dout_d;
         doe_q  <= doe_d;
         pout_q <= pout_d;
         poe_q  <= poe_d;
         ackn_q <= ackn_d;
         tean_q <= tean_d;
         rtyo_q <= rtyo_d;
         coe_q  <= coe_d;
         udat_q <= udat_d;
         uctl_q <= uctl_d;
      end
   end

   assign data_o                   = dout_q;
   assign data_oe_n_o              = doe_q;
   assign byte_lane_parity_o       = pout_q;
   assign byte_lane_parity_oe_n_o  = poe_q;
   assign transfer_acknowledge_n_o = ackn_q;
   assign transfer_error_ack_n_o   = tean_q;
   assign retry_request_o          = rtyo_q;
   assign ctl_oe_n_o               = coe_q;
   assign parity_err_o             = perr_q;
   assign sreq_o                   = req_q;
   assign user_data_o              = udat_q;
   assign user_ctl_o               = uctl_q;

endmodule

// File: dv/hpp_props.sv
/*
 checker for hpp_port: terminations, pin enables, lane parity.
 assumes binding to hpp_port and one bus clock.
*/
`timescale 1ns/1ns
module hpp_props
   import hpp_pkg::*;
(
   input wire logic        ref_clk_i,
   input wire logic        rstn_i,
   input wire logic        port_en_i,
   input wire logic        cfg_done_i,
   input wire logic        ts_n_i,
   input wire logic        burst_data_in_progress_i,
   input wire logic [31:0] data_i,
   input wire logic [31:0] data_o,
   input wire logic [31:0] data_oe_n_o,
   input wire logic [3:0]  byte_lane_parity_o,
   input wire logic [3:0]  byte_lane_parity_oe_n_o,
   input wire logic        transfer_acknowledge_n_o,
   input wire logic        transfer_error_ack_n_o,
   input wire logic        retry_request_o,
   input wire hpp_sreq_s   sreq_o,
   input wire hpp_srsp_s   srsp_i,
   input wire logic [31:0] user_data_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rstn_i);
   logic ack;
   logic tea;
   assign ack = !transfer_acknowledge_n_o;
   assign tea = !transfer_error_ack_n_o;
   ////////////////////////////////////////////////////////////////////////
   a_one_term: assert property (
      !(ack && tea) && !((ack || tea) && retry_request_o))
      else $error("two terminations at once");
   a_ack_cause: assert property (
      ack |-> $past(srsp_i.done && !srsp_i.err && !srsp_i.retry, 2))
      else $error("ack without done");
   a_ack_in_time: assert property (
      srsp_i.done && !srsp_i.err && !srsp_i.retry |-> ##2 ack ##1 !ack)
      else $error("ack late or long");
   a_tea_cause: assert property (
      tea |-> $past(srsp_i.err && !srsp_i.retry, 2))
      else $error("error ack without error");
   a_retry_cause: assert property (
      srsp_i.retry |-> ##2 retry_request_o ##1 !retry_request_o)
      else $error("retry not passed on");
   a_req_taken: assert property (
      sreq_o.req |-> $past(!ts_n_i && port_en_i && cfg_done_i) ||
      $past(burst_data_in_progress_i && port_en_i && cfg_done_i))
      else $error("request without start");
   a_oe_with_ack: assert property (
      (data_oe_n_o != '1) |-> ack)
      else $error("data driven outside ack");
   a_lane_par: assert property (
      (byte_lane_parity_oe_n_o == 4'h0) |-> byte_lane_parity_o ==
      {^data_o[31:24], ^data_o[23:16], ^data_o[15:8], ^data_o[7:0]})
      else $error("lane parity wrong");
   a_user_data: assert property (
      !port_en_i |=> user_data_o == $past(data_i))
      else $error("user data not passed");
endmodule
bind hpp_port hpp_props u_props (.*);

// File: dv/hpp_sys_mdl.sv
/*
 internal system bus target: answers each request after a set wait.
 assumes requests one at a time; mode 0 done, 1 error, 2 retry.
*/
`timescale 1ns/1ns
module hpp_sys_mdl
   import hpp_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   input  wire hpp_sreq_s  sreq_i,
   input  wire logic [1:0] mode_i,
   input  wire logic [3:0] lat_i,
   output hpp_srsp_s       srsp_o
);
   logic        busy_q;
   logic [3:0]  cnt_q;
   logic [21:0] addr_q;
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         busy_q <= 1'b0;
         cnt_q  <= 4'h0;
         addr_q <= '0;
         srsp_o <= '0;
      end else begin
         srsp_o.done  <= 1'b0;
         srsp_o.err   <= 1'b0;
         srsp_o.retry <= 1'b0;
         // stale data is never left standing between answers
         srsp_o.rdata <= ~srsp_o.rdata;
         if (sreq_i.req) begin
            busy_q <= 1'b1;
            cnt_q  <= lat_i;
            addr_q <= sreq_i.addr;
         end else if (busy_q && cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
         end else if (busy_q) begin
            busy_q       <= 1'b0;
            srsp_o.done  <= mode_i == 2'h0;
            srsp_o.err   <= mode_i == 2'h1;
            srsp_o.retry <= mode_i == 2'h2;
            srsp_o.rdata <= {10'h0, addr_q} ^ 32'h5A5A0000;
         end
      end
   end
endmodule

// File: dv/tb_top.sv
/*
 bench for hpp_port: master cycles, errors, retry, parity, user pins.
 assumes hpp_sys_mdl as internal bus target and a 32 bit bus, with one 8 bit read.
*/
`timescale 1ns/1ns
module tb_top
   import hpp_pkg::*;
;
   logic clk = 0, rstn = 0, en = 1, ts_n = 1, rd = 0, brst = 0, bdip = 0;
   logic [1:0] sz = 0, mode = 0, bw = 2'h2;
   logic [3:0] lat = 0, par = 0, pout, poe_n, rpar;
   logic [21:0] adr = 0;
   logic [31:0] din = 0, dout, doe_n, udo, rdat, roe, uoe = '1;
   logic ack_n, tea_n, rty, perr, pseen, coe;
   logic [2:0] term, uco;
   hpp_sreq_s sreq, sr_c;
   hpp_srsp_s srsp;
   int mismatches = 0, checks_done = 0;
   initial forever #25 clk = ~clk;
   hpp_sys_mdl u_mdl (.clk_i(clk), .rstn_i(rstn), .sreq_i(sreq),
      .mode_i(mode), .lat_i(lat), .srsp_o(srsp));
   hpp_port u_dut (.ref_clk_i(clk), .rstn_i(rstn), .port_en_i(en),
      .cfg_done_i(1'b1), .bus_width_i(bw), .ts_n_i(ts_n),
      .rd_wr_i(rd), .addr_i(adr), .transfer_size_i(sz), .burst_i(brst),
      .burst_data_in_progress_i(bdip),
      .data_i((din & doe_n) | (dout & ~doe_n)),
      .byte_lane_parity_i((par & poe_n) | (pout & ~poe_n)),
      .data_o(dout), .data_oe_n_o(doe_n), .byte_lane_parity_o(pout),
      .byte_lane_parity_oe_n_o(poe_n),
      .transfer_acknowledge_n_o(ack_n), .transfer_error_ack_n_o(tea_n),
      .retry_request_o(rty), .ctl_oe_n_o(coe), .parity_err_o(perr),
      .sreq_o(sreq), .srsp_i(srsp), .user_data_i(32'h0),
      .user_data_oe_n_i(uoe), .user_ctl_i(3'h0), .user_ctl_oe_n_i(1'b1),
      .user_data_o(udo), .user_ctl_o(uco));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [3:0] lp(input logic [31:0] d);
      return {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
   endfunction
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   // waits for one termination, capturing what stands with it
   task wt;
      term = 0;
      pseen = 0;
      for (int i = 0; i < 20 && term == 0; i++) begin
         if (sreq.req) sr_c = sreq;
         pseen = pseen | perr;
         term = {rty, !tea_n, !ack_n};
         rdat = dout;
         rpar = pout;
         roe = doe_n;
         if (term == 0) begin
            @(posedge clk);
            #1;
         end
      end
   endtask
   task cyc(input logic r, input logic [1:0] s, input logic [31:0] d,
            input logic [3:0] p);
      @(posedge clk);
      #1;
      ts_n = 0;
      rd = r;
      sz = s;
      adr = adr + 22'h4;
      din = d;
      par = p;
      @(posedge clk);
      #1;
      ts_n = 1;
      wt();
   endtask
   task t_write;
      for (int k = 0; k < 3; k++) begin
         cyc(0, k[1:0], 32'hC3A51E0F, lp(32'hC3A51E0F));
         chk("term", 3'h1, term);
         chk("wdata", 32'hC3A51E0F, sr_c.wdata);
         chk("size", k, sr_c.size);
         chk("perr", 0, pseen);
         chk("be", k == 1 ? 4'h1 : k == 2 ? 4'h3 : 4'hF, sr_c.be);
         chk("ctl oe", 0, coe);
      end
      $display("write test done");
   endtask
   task t_read;
      lat = 4'h3;
      cyc(1, 0, 0, 0);
      chk("term", 3'h1, term);
      chk("rdata", {10'h0, adr} ^ 32'h5A5A0000, rdat);
      chk("rpar", lp({10'h0, adr} ^ 32'h5A5A0000), rpar);
      chk("rdoe", 32'h0, roe);
      bw = 2'h0;
      cyc(1, 0, 0, 0);
      chk("term", 3'h1, term);
      chk("rdoe8", 32'hFFFFFF00, roe);
      bw = 2'h2;
      lat = 4'h0;
      $display("read test done");
   endtask
   task t_fault;
      mode = 2'h1;
      cyc(1, 0, 0, 0);
      chk("term", 3'h2, term);
      mode = 2'h2;
      cyc(0, 0, 0, 0);
      chk("term", 3'h4, term);
      @(posedge clk);
      #1;
      chk("uctl", 3'h1, uco);
      mode = 2'h0;
      cyc(0, 0, 32'h0F0F00FF, 4'h3);
      chk("perr", 1, pseen);
      $display("fault test done");
   endtask
   // one extra beat, then the master drops the request to end the burst
   task t_burst;
      brst = 1;
      bdip = 1;
      cyc(1, 0, 0, 0);
      chk("term", 3'h1, term);
      chk("beat req", 1, sreq.req);
      chk("beat addr", adr + 22'h4, sreq.addr);
      brst = 0;
      bdip = 0;
      @(posedge clk);
      #1;
      wt();
      chk("term", 3'h1, term);
      chk("rdata", {10'h0, adr + 22'h4} ^ 32'h5A5A0000, rdat);
      chk("abort", 0, sreq.req);
      $display("burst test done");
   endtask
   task t_user;
      en = 0;
      ts_n = 0;
      din = 32'h13579BDF;
      repeat (2) @(posedge clk);
      #1;
      chk("udata", din, udo);
      chk("req", 0, sreq.req);
      chk("ctl oe", 1, coe);
      ts_n = 1;
      en = 1;
      $display("user pin test done");
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      #1;
      rstn = 1;
      t_write();
      t_read();
      t_burst();
      t_fault();
      t_user();
      end_sim();
   end
   initial begin
      repeat (2000) @(posedge clk);
      mismatches++;
      end_sim();
   end
endmodule
